// ===== rtl/spc_pkg.sv
// Package: register map, field layout, reset values and types for the port config bank
package spc_pkg;
  // Register indexes, kept as printed; byte address is four times the index
  localparam logic [7:0] SPC_IDX_MODE    = 8'hF0;
  localparam logic [7:0] SPC_IDX_OPT     = 8'hF1;
  localparam logic [7:0] SPC_IDX_HDX     = 8'hF2;
  localparam logic [7:0] SPC_IDX_TEST    = 8'hF8;
  // Own register for the block's status and event bits
  localparam logic [7:0] SPC_IDX_STATUS  = 8'hFC;
  // Logical device windows on address bits [9:8]
  localparam logic [1:0] SPC_DEV_SER_TWO = 2'h0;
  localparam logic [1:0] SPC_DEV_PAR     = 2'h1;
  localparam logic [1:0] SPC_DEV_SER_ONE = 2'h2;
  // Reset values
  localparam logic [7:0] SPC_RST_SER_TWO = 8'h00;
  localparam logic [7:0] SPC_RST_SER_ONE = 8'h00;
  localparam logic [7:0] SPC_RST_IR_OPT  = 8'h02;
  localparam logic [7:0] SPC_RST_IR_HDX  = 8'h03;
  localparam logic [7:0] SPC_RST_PAR     = 8'h3C;
  localparam logic [7:0] SPC_RST_PAR_TWO = 8'h00;
  localparam logic [7:0] SPC_RST_TEST    = 8'h08;
  // Writable masks; reserved bits store and read zero
  localparam logic [7:0] SPC_MSK_SER_TWO = 8'h03;
  localparam logic [7:0] SPC_MSK_SER_ONE = 8'h83;
  localparam logic [7:0] SPC_MSK_IR_OPT  = 8'hFF;
  localparam logic [7:0] SPC_MSK_IR_HDX  = 8'hFF;
  localparam logic [7:0] SPC_MSK_PAR     = 8'hFF;
  localparam logic [7:0] SPC_MSK_PAR_TWO = 8'h10;
  // Field positions
  localparam int SPC_BIT_MIDI      = 0;
  localparam int SPC_BIT_HSPEED    = 1;
  localparam int SPC_BIT_SHARE     = 7;
  localparam int SPC_BIT_IR_POL    = 0;
  localparam int SPC_BIT_PIRQ_TYPE = 7;
  localparam int SPC_BIT_TO_SEL    = 4;
  localparam int SPC_BIT_TO_FLAG   = 0;
  localparam int SPC_LSB_THRESH    = 3;
  // Timing
  localparam int SPC_CLK_MHZ       = 200;
  localparam int SPC_HDX_STEP_US   = 100;
  localparam int SPC_HDX_STEP_CYC  = SPC_HDX_STEP_US * SPC_CLK_MHZ;
  localparam int SPC_HDX_MAX_CNT   = 100;
  localparam int SPC_PULSE_CYC     = 2;

  // Parallel port mode encodings
  typedef enum logic [2:0] {
    SPC_PM_SPP     = 3'b000,
    SPC_PM_EPP19   = 3'b001,
    SPC_PM_ECP     = 3'b010,
    SPC_PM_ECP19   = 3'b011,
    SPC_PM_PRINTER = 3'b100,
    SPC_PM_EPP17   = 3'b101,
    SPC_PM_RSVD    = 3'b110,
    SPC_PM_ECP17   = 3'b111
  } spc_pmode_t;

  // Parallel interrupt pin drive states
  typedef enum logic [2:0] {
    SPC_PI_IDLE  = 3'b001,
    SPC_PI_PULSE = 3'b010,
    SPC_PI_WAIT  = 3'b100
  } spc_pirq_t;

  // Avalon-MM request from the bus
  typedef struct packed {
    logic [9:0] address;
    logic       read;
    logic       write;
    logic [7:0] writedata;
  } spc_av_req_t;

  // Decoded configuration to the port datapaths
  typedef struct packed {
    logic       s1_midi;
    logic       s1_hspeed;
    logic       s2_midi;
    logic       s2_hspeed;
    logic       ir_rx_pol;
    logic [7:0] ir_option;
    logic [3:0] ecp_thresh;
    spc_pmode_t par_mode;
  } spc_cfg_t;
endpackage : spc_pkg

// ===== rtl/spc_regs.sv
// Config register bank for two serial ports, infrared option and parallel port
//
// Operation
// - Mode bit 0 enables MIDI, reset off
// - Mode bit 1 enables high speed, reset off
// - Serial one bit 7 shares one interrupt line
// - Infrared option resets 0x02, bit 0 polarity
// - Half-duplex timeout 0-10 ms, 100 us steps
// - Zero blanks during transmit only; reset 0x03
// - Parallel mode bits 2:0 select operating mode
// - Bits 6:3 hold ECP threshold, default 0111
// - Type bit set: pulse low, release high-Z
// - Type clear: follow ack or level type
// - Type bit ignored in printer, standard modes
// - Select zero: flag clears on written one
// - Select one: flag clears after status read
// - Sharing with distinct lines asserts both lines
`timescale 1ns/1ps
module spc_regs
  import spc_pkg::*;
#(
  parameter int HDX_STEP_CYC = spc_pkg::SPC_HDX_STEP_CYC
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  // Avalon-MM slave
  input  wire spc_pkg::spc_av_req_t av_req_i,
  output logic [31:0]             av_readdata_o,
  output logic                    av_waitrequest_o,
  // Serial port interrupt requests and line assignment
  input  wire logic               ser1_irq_req_i,
  input  wire logic               ser2_irq_req_i,
  input  wire logic               ser1_irq_sel_i,
  input  wire logic               ser2_irq_sel_i,
  output logic                    ser1_irq_o,
  output logic                    ser2_irq_o,
  // Infrared transmit activity and receive blank
  input  wire logic               ir_tx_active_i,
  output logic                    ir_rx_blank_o,
  // Parallel port events
  input  wire logic               par_ack_n_i,
  input  wire logic               par_level_irq_i,
  input  wire logic               epp_timeout_evt_i,
  input  wire logic               epp_status_rd_i,
  input  wire logic               epp_flag_wr_one_i,
  output logic                    par_irq_o,
  output logic                    par_irq_oe_n_o,
  output logic                    epp_timeout_flag_o,
  // Decoded configuration
  output spc_pkg::spc_cfg_t       cfg_o
);
  import spc_pkg::*;

  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [7:0]  ser_two;
    logic [7:0]  ser_one;
    logic [7:0]  ir_opt;
    logic [7:0]  ir_hdx;
    logic [7:0]  par;
    logic [7:0]  par_two;
    logic [7:0]  test;
    logic [2:0]  ack_sync;
    logic        ack_prev;
    logic        rd_prev;
    logic        flag;
    logic        rd_done;
    logic [31:0] rdata;
    logic        irq1;
    logic        irq2;
    logic        blank;
    logic [15:0] step_cnt;
    logic [7:0]  hdx_cnt;
    spc_pirq_t   pst;
    logic [1:0]  pcnt;
    logic        pirq;
    logic        poe_n;
    spc_cfg_t    cfg;
  } spc_state_t;

  spc_state_t st_reg;
  spc_state_t st_next;

  // Reset release: two flops, then the synchronous copy loads defaults into all state
  logic [1:0] rst_pipe_reg;
  logic       rst_n_sync;
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe_reg[1];

  // True for modes where the interrupt type bit matters
  function automatic logic spc_type_valid(input spc_pmode_t m);
    spc_type_valid = (m != SPC_PM_PRINTER) && (m != SPC_PM_SPP);
  endfunction : spc_type_valid

  // True for modes carrying an EPP or ack-following interrupt
  function automatic logic spc_follows_ack(input spc_pmode_t m);
    spc_follows_ack = (m == SPC_PM_EPP19) || (m == SPC_PM_EPP17) ||
                      (m == SPC_PM_ECP19) || (m == SPC_PM_ECP17);
  endfunction : spc_follows_ack

  // Byte index and device window from the word address
  logic [7:0] idx;
  logic [1:0] dev;
  logic       acc;
  logic       ack_fall;
  logic       rd_trail;
  logic       any_irq;
  // Full low byte decodes, so F1 and F2 stay distinct from F0
  assign idx = av_req_i.address[7:0];
  assign dev = av_req_i.address[9:8];

  always_comb begin
    st_next = st_reg;
    acc = (av_req_i.read || av_req_i.write) && !st_reg.rd_done;
    st_next.rd_done = acc;
    st_next.rdata = 32'h0;
    // Register writes, one wait cycle per access
    if (acc && av_req_i.write) begin
      if (dev == SPC_DEV_SER_TWO && idx == SPC_IDX_MODE) begin
        st_next.ser_two = av_req_i.writedata & SPC_MSK_SER_TWO;
      end else if (dev == SPC_DEV_SER_TWO && idx == SPC_IDX_OPT) begin
        st_next.ir_opt = av_req_i.writedata & SPC_MSK_IR_OPT;
      end else if (dev == SPC_DEV_SER_TWO && idx == SPC_IDX_HDX) begin
        st_next.ir_hdx = av_req_i.writedata & SPC_MSK_IR_HDX;
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_MODE) begin
        st_next.par = av_req_i.writedata & SPC_MSK_PAR;
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_OPT) begin
        st_next.par_two = av_req_i.writedata & SPC_MSK_PAR_TWO;
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_TEST) begin
        st_next.test = av_req_i.writedata;
      end else if (dev == SPC_DEV_SER_ONE && idx == SPC_IDX_MODE) begin
        st_next.ser_one = av_req_i.writedata & SPC_MSK_SER_ONE;
      end
    end
    // Register reads; unmapped addresses read zero
    if (acc && av_req_i.read) begin
      if (dev == SPC_DEV_SER_TWO && idx == SPC_IDX_MODE) begin
        st_next.rdata = {24'h0, st_reg.ser_two};
      end else if (dev == SPC_DEV_SER_TWO && idx == SPC_IDX_OPT) begin
        st_next.rdata = {24'h0, st_reg.ir_opt};
      end else if (dev == SPC_DEV_SER_TWO && idx == SPC_IDX_HDX) begin
        st_next.rdata = {24'h0, st_reg.ir_hdx};
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_MODE) begin
        st_next.rdata = {24'h0, st_reg.par};
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_OPT) begin
        st_next.rdata = {24'h0, st_reg.par_two};
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_TEST) begin
        st_next.rdata = {24'h0, st_reg.test};
      end else if (dev == SPC_DEV_PAR && idx == SPC_IDX_STATUS) begin
        st_next.rdata = {31'h0, st_reg.flag};
      end else if (dev == SPC_DEV_SER_ONE && idx == SPC_IDX_MODE) begin
        st_next.rdata = {24'h0, st_reg.ser_one};
      end
    end

    // Ack pin: three flops, edge counts once flops two and three agree
    st_next.ack_sync = {st_reg.ack_sync[1:0], par_ack_n_i};
    if (st_reg.ack_sync[2] == st_reg.ack_sync[1]) begin
      st_next.ack_prev = st_reg.ack_sync[2];
    end
    ack_fall = st_reg.ack_prev && (st_reg.ack_sync[2] == st_reg.ack_sync[1])
               && !st_reg.ack_sync[2];

    // Timeout flag: set wins over either clear
    st_next.rd_prev = epp_status_rd_i;
    rd_trail = st_reg.rd_prev && !epp_status_rd_i;
    if (st_reg.par_two[SPC_BIT_TO_SEL] && rd_trail) begin
      st_next.flag = 1'b0;
    end else if (!st_reg.par_two[SPC_BIT_TO_SEL] && epp_flag_wr_one_i) begin
      st_next.flag = 1'b0;
    end
    if (epp_timeout_evt_i) begin
      st_next.flag = 1'b1;
    end

    // Serial lines: sharing drives both lines from either request unless only one line is selected
    any_irq = ser1_irq_req_i || ser2_irq_req_i;
    if (st_reg.ser_one[SPC_BIT_SHARE]) begin
      // Sharing with distinct lines asserts both
      st_next.irq1 = any_irq && (ser1_irq_sel_i || !ser2_irq_sel_i);
      st_next.irq2 = any_irq && (ser2_irq_sel_i || !ser1_irq_sel_i);
    end else begin
      st_next.irq1 = ser1_irq_req_i;
      st_next.irq2 = ser2_irq_req_i;
    end

    // Half-duplex blank: count whole 100 us steps after transmit ends
    if (ir_tx_active_i) begin
      st_next.blank = 1'b1;
      st_next.hdx_cnt = (st_reg.ir_hdx > 8'(SPC_HDX_MAX_CNT)) ?
                        8'(SPC_HDX_MAX_CNT) : st_reg.ir_hdx;
      st_next.step_cnt = 16'h0;
    end else if (st_reg.hdx_cnt != 8'h0) begin
      st_next.blank = 1'b1;
      if (st_reg.step_cnt == 16'(HDX_STEP_CYC - 1)) begin
        st_next.step_cnt = 16'h0;
        st_next.hdx_cnt = st_reg.hdx_cnt - 8'h1;
      end else begin
        st_next.step_cnt = st_reg.step_cnt + 16'h1;
      end
    end else begin
      st_next.blank = 1'b0;
    end

    // Parallel interrupt drive
    if (spc_type_valid(st_reg.cfg.par_mode) && st_reg.par[SPC_BIT_PIRQ_TYPE]) begin
      // Pulsed style: low pulse then release to high-Z
      case (st_reg.pst)
        SPC_PI_IDLE: begin
          st_next.pirq = 1'b1;
          st_next.poe_n = 1'b1;
          if (par_level_irq_i || ack_fall) begin
            st_next.pst = SPC_PI_PULSE;
            st_next.pirq = 1'b0;
            st_next.poe_n = 1'b0;
            st_next.pcnt = 2'(SPC_PULSE_CYC - 1);
          end
        end
        SPC_PI_PULSE: begin
          if (st_reg.pcnt == 2'h0) begin
            st_next.pst = SPC_PI_WAIT;
            st_next.poe_n = 1'b1;
          end else begin
            st_next.pcnt = st_reg.pcnt - 2'h1;
          end
        end
        SPC_PI_WAIT: begin
          // Hold off until the level source drops, so one event gives one pulse
          if (!par_level_irq_i) begin
            st_next.pst = SPC_PI_IDLE;
          end
        end
        default: st_next.pst = SPC_PI_IDLE;
      endcase
    end else begin
      st_next.pst = SPC_PI_IDLE;
      st_next.poe_n = 1'b0;
      if (spc_follows_ack(st_reg.cfg.par_mode) || !spc_type_valid(st_reg.cfg.par_mode)) begin
        st_next.pirq = !st_reg.ack_prev;
      end else begin
        st_next.pirq = par_level_irq_i;
      end
    end

    // Decoded configuration outputs
    st_next.cfg.s1_midi    = st_reg.ser_one[SPC_BIT_MIDI];
    st_next.cfg.s2_midi    = st_reg.ser_two[SPC_BIT_MIDI];
    st_next.cfg.s1_hspeed  = st_reg.ser_one[SPC_BIT_HSPEED];
    st_next.cfg.s2_hspeed  = st_reg.ser_two[SPC_BIT_HSPEED];
    st_next.cfg.ir_rx_pol  = st_reg.ir_opt[SPC_BIT_IR_POL];
    st_next.cfg.ir_option  = st_reg.ir_opt;
    st_next.cfg.ecp_thresh = st_reg.par[SPC_LSB_THRESH +: 4];
    st_next.cfg.par_mode   = spc_pmode_t'(st_reg.par[2:0]);
    st_next.rst_sync = 2'h3;

    // Synchronous reset copy puts every register at its default
    if (!rst_n_sync) begin
      st_next = '0;
      st_next.ser_two  = SPC_RST_SER_TWO;
      st_next.ser_one  = SPC_RST_SER_ONE;
      st_next.ir_opt   = SPC_RST_IR_OPT;
      st_next.ir_hdx   = SPC_RST_IR_HDX;
      st_next.par      = SPC_RST_PAR;
      st_next.par_two  = SPC_RST_PAR_TWO;
      st_next.test     = SPC_RST_TEST;
      st_next.ack_sync = 3'h7;
      st_next.ack_prev = 1'b1;
      st_next.pst      = SPC_PI_IDLE;
      st_next.cfg.par_mode = spc_pmode_t'(SPC_RST_PAR[2:0]);
      st_next.cfg.ecp_thresh = SPC_RST_PAR[SPC_LSB_THRESH +: 4];
      st_next.cfg.ir_option = SPC_RST_IR_OPT;
      st_next.cfg.ir_rx_pol = SPC_RST_IR_OPT[SPC_BIT_IR_POL];
    end
  end

  // State register; async reset loads zero, sync copy loads defaults
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign av_readdata_o      = st_reg.rdata;
  assign av_waitrequest_o   = !st_reg.rd_done; // Low in the answer cycle only
  assign ser1_irq_o         = st_reg.irq1;
  assign ser2_irq_o         = st_reg.irq2;
  assign ir_rx_blank_o      = st_reg.blank;
  assign par_irq_o          = st_reg.pirq;
  assign par_irq_oe_n_o     = st_reg.poe_n;
  assign epp_timeout_flag_o = st_reg.flag;
  assign cfg_o              = st_reg.cfg;
endmodule : spc_regs

// ===== tb/spc_regs_chk.sv
// Checker: port-level properties of the config register bank
`timescale 1ns/1ps
module spc_regs_chk
  import spc_pkg::*;
(
  // Clock, reset and bus
  input wire logic                 sys_clk_i,
  input wire logic                 rst_n_i,
  input wire spc_pkg::spc_av_req_t av_req_i,
  input wire logic [31:0]          av_readdata_o,
  input wire logic                 av_waitrequest_o,
  // Serial interrupts
  input wire logic                 ser1_irq_req_i,
  input wire logic                 ser2_irq_req_i,
  input wire logic                 ser1_irq_sel_i,
  input wire logic                 ser1_irq_o,
  input wire logic                 ser2_irq_o,
  // Infrared blank, parallel events
  input wire logic                 ir_tx_active_i,
  input wire logic                 ir_rx_blank_o,
  input wire logic                 par_irq_o,
  input wire logic                 par_irq_oe_n_o,
  input wire logic                 epp_timeout_evt_i,
  input wire logic                 epp_status_rd_i,
  input wire logic                 epp_flag_wr_one_i,
  input wire logic                 epp_timeout_flag_o,
  input wire spc_pkg::spc_cfg_t    cfg_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Bus handshake and standard-mode steps
  sequence s_answer;
    !av_waitrequest_o ##1 av_waitrequest_o;
  endsequence
  sequence s_std_mode;
    (cfg_o.par_mode == SPC_PM_PRINTER || cfg_o.par_mode == SPC_PM_SPP) [*3];
  endsequence
  a_wait_one_cycle: assert property ((av_req_i.read || av_req_i.write) && av_waitrequest_o |=> s_answer) else $error("answer not after one wait cycle");
  a_unmapped_zero: assert property (av_req_i.read && av_waitrequest_o && av_req_i.address[9:8] == 2'h3 |=> av_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_ser_two_rsvd: assert property (av_req_i.read && av_waitrequest_o && av_req_i.address == {SPC_DEV_SER_TWO, SPC_IDX_MODE} |=> av_readdata_o[7:2] == 6'h0) else $error("reserved bits read nonzero");
  a_irq_quiet: assert property (!ser1_irq_req_i && !ser2_irq_req_i |=> !ser1_irq_o && !ser2_irq_o) else $error("serial irq without request");
  a_irq_follow: assert property (ser1_irq_req_i && ser1_irq_sel_i |=> ser1_irq_o) else $error("serial one irq missing");
  a_pulse_release: assert property ($rose(par_irq_oe_n_o) |-> $past(!par_irq_o) && $past(!par_irq_oe_n_o)) else $error("release without low pulse");
  a_std_no_pulse: assert property (s_std_mode |-> !par_irq_oe_n_o) else $error("pulse in standard mode");
  a_flag_set: assert property (epp_timeout_evt_i |=> epp_timeout_flag_o) else $error("timeout flag not set");
  a_flag_hold: assert property (epp_timeout_flag_o && !epp_flag_wr_one_i && !epp_status_rd_i && !$past(epp_status_rd_i) |=> epp_timeout_flag_o) else $error("flag cleared spuriously");
  a_blank_tx: assert property (ir_tx_active_i |=> ir_rx_blank_o) else $error("no blank during transmit");
endmodule : spc_regs_chk

bind spc_regs spc_regs_chk u_chk (.sys_clk_i, .rst_n_i, .av_req_i, .av_readdata_o,
  .av_waitrequest_o, .ser1_irq_req_i, .ser2_irq_req_i, .ser1_irq_sel_i, .ser1_irq_o,
  .ser2_irq_o, .ir_tx_active_i, .ir_rx_blank_o, .par_irq_o, .par_irq_oe_n_o,
  .epp_timeout_evt_i, .epp_status_rd_i, .epp_flag_wr_one_i, .epp_timeout_flag_o, .cfg_o);

// ===== tb/spc_regs_test.sv
// Testbench: bus tasks and port scenarios for the config register bank
`timescale 1ns/1ps
module spc_regs_test;
  import spc_pkg::*;
  logic sys_clk, rst_n = 1'b0, wreq, s1r = 0, s2r = 0, s1s = 1, s2s = 1, tx = 0, ack_n = 1;
  logic lvl = 0, evt = 0, srd = 0, wr1 = 0, irq1, irq2, blank, pirq, poe_n, flag;
  spc_av_req_t req = '0;
  logic [31:0] rdata;
  spc_cfg_t    cfg;
  logic [7:0]  q;
  logic [2:0]  modes [7] = '{3'b100, 3'b000, 3'b001, 3'b101, 3'b010, 3'b011, 3'b111};
  int bad_count = 0, num_checks = 0, cyc_count = 0;
  localparam logic [9:0] SER2 = {SPC_DEV_SER_TWO, SPC_IDX_MODE};
  localparam logic [9:0] SER1 = {SPC_DEV_SER_ONE, SPC_IDX_MODE};
  localparam logic [9:0] PARM = {SPC_DEV_PAR, SPC_IDX_MODE};
  spc_regs #(.HDX_STEP_CYC(4)) uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .av_req_i(req),
    .av_readdata_o(rdata), .av_waitrequest_o(wreq), .ser1_irq_req_i(s1r),
    .ser2_irq_req_i(s2r), .ser1_irq_sel_i(s1s), .ser2_irq_sel_i(s2s), .ser1_irq_o(irq1),
    .ser2_irq_o(irq2), .ir_tx_active_i(tx), .ir_rx_blank_o(blank), .par_ack_n_i(ack_n),
    .par_level_irq_i(lvl), .epp_timeout_evt_i(evt), .epp_status_rd_i(srd),
    .epp_flag_wr_one_i(wr1), .par_irq_o(pirq), .par_irq_oe_n_o(poe_n),
    .epp_timeout_flag_o(flag), .cfg_o(cfg));
  // Free-running 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Hang guard well above the expected run length
  always @(posedge sys_clk) begin
    cyc_count++;
    if (cyc_count == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req <= '{address: a, read: !wr, write: wr, writedata: d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    if (n >= 50) bad_count++;
    req <= '0;
  endtask : bus
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask : rd
  // Let n edges pass, then look at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle(6);
    // Defaults after reset
    chk(8'(cfg.par_mode), 8'h04);
    chk(8'(cfg.ecp_thresh), 8'h07);
    chk(cfg.ir_option, 8'h02);
    chk({cfg.s1_midi, cfg.s1_hspeed, cfg.s2_midi, cfg.s2_hspeed, cfg.ir_rx_pol}, 8'h00);
    rd(SER2, 8'h00);
    rd(PARM, 8'h3C);
    rd(SER1, 8'h00);
    rd({SPC_DEV_PAR, SPC_IDX_TEST}, 8'h08);
    rd(10'h3F0, 8'h00);
    rd({SPC_DEV_SER_TWO, SPC_IDX_OPT}, 8'h02);
    rd({SPC_DEV_SER_TWO, SPC_IDX_HDX}, 8'h03);
    // Reserved bits drop, live bits act at once
    bus(1'b1, SER2, 8'hFF);
    rd(SER2, 8'h03);
    bus(1'b1, SER1, 8'hFD);
    rd(SER1, 8'h81);
    settle(1);
    chk({cfg.s1_midi, cfg.s1_hspeed, cfg.s2_midi, cfg.s2_hspeed}, 8'h0B);
    // Every parallel mode but the reserved one, threshold walked from its top value
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, PARM, {1'b0, 4'hF ^ 4'(i), modes[i]});
      rd(PARM, {1'b0, 4'hF ^ 4'(i), modes[i]});
      settle(1);
      chk(8'(cfg.par_mode), 8'(modes[i]));
      chk(8'(cfg.ecp_thresh), 8'(4'hF ^ 4'(i)));
    end
    // Serial lines: separate, shared, shared with one line selected
    bus(1'b1, SER1, 8'h00);
    s1r <= 1'b1;
    settle(2);
    chk({irq1, irq2}, 8'h02);
    @(posedge sys_clk);
    s1r <= 1'b0;
    bus(1'b1, SER1, 8'h80);
    s2r <= 1'b1;
    settle(2);
    chk({irq1, irq2}, 8'h03);
    @(posedge sys_clk);
    s2r <= 1'b0;
    s2s <= 1'b0;
    s1r <= 1'b1;
    settle(2);
    chk({irq1, irq2}, 8'h02);
    @(posedge sys_clk);
    s1r <= 1'b0;
    bus(1'b1, SER1, 8'h00);
    // Type bit set but standard mode: ack is followed, no pulse
    bus(1'b1, PARM, 8'hB8);
    ack_n <= 1'b0;
    settle(6);
    chk({pirq, poe_n}, 8'h02);
    @(posedge sys_clk);
    ack_n <= 1'b1;
    // Level style in plain ECP mode
    bus(1'b1, PARM, 8'h3A);
    lvl <= 1'b1;
    settle(3);
    chk({pirq, poe_n}, 8'h02);
    @(posedge sys_clk);
    lvl <= 1'b0;
    // Pulse style: drive low, then release
    bus(1'b1, PARM, 8'hBA);
    settle(3);
    chk(8'(poe_n), 8'h01);
    @(posedge sys_clk);
    lvl <= 1'b1;
    settle(1);
    chk({pirq, poe_n}, 8'h00);
    settle(5);
    chk({pirq, poe_n}, 8'h01);
    @(posedge sys_clk);
    lvl <= 1'b0;
    // Timeout flag with default select: a status read leaves it set
    evt <= 1'b1;
    @(posedge sys_clk);
    evt <= 1'b0;
    settle(1);
    chk(8'(flag), 8'h01);
    rd({SPC_DEV_PAR, SPC_IDX_STATUS}, 8'h01);
    srd <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srd <= 1'b0;
    settle(3);
    chk(8'(flag), 8'h01);
    @(posedge sys_clk);
    wr1 <= 1'b1;
    @(posedge sys_clk);
    wr1 <= 1'b0;
    settle(1);
    chk(8'(flag), 8'h00);
    // Select one: the trailing edge of a status read clears the flag
    bus(1'b1, {SPC_DEV_PAR, SPC_IDX_OPT}, 8'h10);
    rd({SPC_DEV_PAR, SPC_IDX_OPT}, 8'h10);
    evt <= 1'b1;
    @(posedge sys_clk);
    evt <= 1'b0;
    srd <= 1'b1;
    @(posedge sys_clk);
    srd <= 1'b0;
    settle(2);
    chk(8'(flag), 8'h00);
    // Receive blank: default count 3 at 4 cycles a step
    @(posedge sys_clk);
    tx <= 1'b1;
    repeat (3) @(posedge sys_clk);
    tx <= 1'b0;
    settle(8);
    chk(8'(blank), 8'h01);
    settle(15);
    chk(8'(blank), 8'h00);
    end_of_test();
  end
endmodule : spc_regs_test
